// file: design/cbt_core.sv
// bit timing engine and receive word hand-off of the can controller
`timescale 1ns/1ps
module cbt_core #(
    parameter int ADR_W = cbt_pkg::ADR_W,
    parameter int MSG_WORDS = cbt_pkg::MSG_WORDS,
    parameter int WORD_W = cbt_pkg::WORD_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [cbt_pkg::DAT_W-1:0] wb_dat_i,
    output logic [cbt_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic can_rx_pin,
    input wire logic frame_idle,
    output logic rx_bit,
    output logic rx_bit_valid,
    input wire logic msg_wr_en,
    input wire logic [WORD_W-1:0] msg_wr_data,
    output logic rx_dma_req
);
    localparam int PTR_W = $clog2(MSG_WORDS);
    localparam logic [PTR_W-1:0] LAST = PTR_W'(MSG_WORDS - 1);
    // ==========================================================
    // wishbone slave: ack one cycle after request, one cycle wide
    logic ack_r;
    logic [cbt_pkg::DAT_W-1:0] dat_r;
    logic [cbt_pkg::DAT_W-1:0] rd_mux;
    logic acc;
    logic wr_go;
    logic rd_go;
    assign acc = wb_cyc_i && wb_stb_i;
    assign wr_go = acc && ack_r && wb_we_i;
    assign rd_go = acc && ack_r && !wb_we_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= acc && !ack_r;
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            dat_r <= '0;
        else if (acc && !ack_r)
            dat_r <= rd_mux;
    end
    // ==========================================================
    // configuration and mode registers
    logic [cbt_pkg::BRP_W-1:0] brp_r;
    logic [cbt_pkg::JW_W-1:0] jw_r;
    logic [cbt_pkg::SEG_W-1:0] prop_r;
    logic [cbt_pkg::SEG_W-1:0] ph1_r;
    logic [cbt_pkg::SEG_W-1:0] ph2_r;
    logic tsel_r;
    logic p2src_r;
    logic [cbt_pkg::MODE_W-1:0] req_mode_r;
    logic [cbt_pkg::MODE_W-1:0] cur_mode_r;
    logic cfg_mode;
    logic run;
    assign cfg_mode = (cur_mode_r == cbt_pkg::MODE_CFG);
    assign run = !cfg_mode;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {jw_r, brp_r} <= cbt_pkg::CFG_A_RST;
            {ph2_r, p2src_r, tsel_r, ph1_r, prop_r} <= cbt_pkg::CFG_B_RST;
        end
        else if (wr_go && cfg_mode)
        begin
            if (wb_adr_i == cbt_pkg::ADR_CFG_A && wb_sel_i[0])
            begin
                brp_r <= wb_dat_i[cbt_pkg::BRP_LSB +: cbt_pkg::BRP_W];
                jw_r <= wb_dat_i[cbt_pkg::JW_LSB +: cbt_pkg::JW_W];
            end
            if (wb_adr_i == cbt_pkg::ADR_CFG_B && wb_sel_i[0])
            begin
                prop_r <= wb_dat_i[cbt_pkg::PROP_LSB +: cbt_pkg::SEG_W];
                ph1_r <= wb_dat_i[cbt_pkg::PH1_LSB +: cbt_pkg::SEG_W];
                tsel_r <= wb_dat_i[cbt_pkg::TSEL_BIT];
                p2src_r <= wb_dat_i[cbt_pkg::P2SRC_BIT];
            end
            if (wb_adr_i == cbt_pkg::ADR_CFG_B && wb_sel_i[1])
                ph2_r <= wb_dat_i[cbt_pkg::PH2_LSB +: cbt_pkg::SEG_W];
        end
    end
    // mode only changes between frames so a bit is never cut short
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            req_mode_r <= cbt_pkg::MODE_CFG;
            cur_mode_r <= cbt_pkg::MODE_CFG;
        end
        else
        begin
            if (wr_go && wb_adr_i == cbt_pkg::ADR_CTRL && wb_sel_i[0])
                req_mode_r <= wb_dat_i[cbt_pkg::REQ_LSB +: cbt_pkg::MODE_W];
            if (frame_idle)
                cur_mode_r <= req_mode_r;
        end
    end
    // ==========================================================
    // segment lengths in quanta
    logic [3:0] prop_tq;
    logic [3:0] ph1_tq;
    logic [3:0] ph2_tq;
    logic [3:0] sjw_tq;
    logic [4:0] bit_tq;
    logic cfg_err;
    assign prop_tq = {1'b0, prop_r} + cbt_pkg::LEN_OFS;
    assign ph1_tq = {1'b0, ph1_r} + cbt_pkg::LEN_OFS;
    assign ph2_tq = p2src_r ? {1'b0, ph2_r} + cbt_pkg::LEN_OFS : ph1_tq;
    assign sjw_tq = {2'b00, jw_r} + cbt_pkg::LEN_OFS;
    assign bit_tq = {1'b0, cbt_pkg::LEN_OFS} + {1'b0, prop_tq} + {1'b0, ph1_tq} + {1'b0, ph2_tq};
    assign cfg_err = (bit_tq < cbt_pkg::TQ_MIN) || (bit_tq > cbt_pkg::TQ_MAX);
    // ==========================================================
    // quantum tick and bus input
    logic tq_tick;
    logic bus_lvl;
    cbt_tq_gen #(.BRP_W(cbt_pkg::BRP_W)) u_tq (
        .ref_clk(ref_clk),
        .rst(rst),
        .en(run),
        .quantum_prescaler(brp_r),
        .tq_tick(tq_tick)
    );
    cbt_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(can_rx_pin),
        .level(bus_lvl)
    );
    // ==========================================================
    // bit segment sequencer
    cbt_pkg::cbt_seg_t seg_r;
    logic [3:0] cnt_r;
    logic [3:0] ext_r;
    logic [3:0] shr_r;
    logic synced_r;
    logic [2:0] samp_r;
    logic fall;
    logic hard;
    logic resync;
    logic [4:0] perr;
    logic [3:0] late_ext;
    logic [3:0] ext_use;
    logic [3:0] rem;
    logic ph1_end;
    logic ph2_end;
    logic maj;
    // edges are seen on quantum resolution, recessive to dominant only
    assign fall = tq_tick && samp_r[0] && !bus_lvl;
    assign hard = fall && frame_idle;
    assign resync = fall && !frame_idle && !synced_r && seg_r != cbt_pkg::SEG_SYNC;
    assign perr = (seg_r == cbt_pkg::SEG_PROP) ? {1'b0, cnt_r} + 5'h01
                : {1'b0, prop_tq} + {1'b0, cnt_r} + 5'h01;
    assign late_ext = (perr > {1'b0, sjw_tq}) ? sjw_tq : perr[3:0];
    assign ext_use = (resync && seg_r != cbt_pkg::SEG_PH2) ? late_ext : ext_r;
    assign rem = ph2_tq - shr_r - cnt_r;
    assign ph1_end = (seg_r == cbt_pkg::SEG_PH1) && (cnt_r == ph1_tq + ext_use - cbt_pkg::LEN_OFS);
    assign ph2_end = (seg_r == cbt_pkg::SEG_PH2) && (cnt_r == ph2_tq - shr_r - cbt_pkg::LEN_OFS);
    assign maj = (samp_r[0] & samp_r[1]) | (samp_r[0] & bus_lvl) | (samp_r[1] & bus_lvl);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            samp_r <= 3'h7;
        else if (tq_tick)
            samp_r <= {samp_r[1:0], bus_lvl};
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            seg_r <= cbt_pkg::SEG_SYNC;
            cnt_r <= '0;
            ext_r <= '0;
            shr_r <= '0;
            synced_r <= 1'b0;
        end
        else if (!run)
        begin
            seg_r <= cbt_pkg::SEG_SYNC;
            cnt_r <= '0;
            ext_r <= '0;
            shr_r <= '0;
            synced_r <= 1'b0;
        end
        else if (tq_tick)
        begin
            if (hard)
            begin
                // this quantum becomes the sync segment
                seg_r <= cbt_pkg::SEG_PROP;
                cnt_r <= '0;
                ext_r <= '0;
                shr_r <= '0;
                synced_r <= 1'b1;
            end
            else
            begin
                case (seg_r)
                    cbt_pkg::SEG_SYNC:
                    begin
                        seg_r <= cbt_pkg::SEG_PROP;
                        cnt_r <= '0;
                    end
                    cbt_pkg::SEG_PROP:
                    begin
                        if (resync)
                        begin
                            ext_r <= late_ext;
                            synced_r <= 1'b1;
                        end
                        if (cnt_r == prop_tq - cbt_pkg::LEN_OFS)
                        begin
                            seg_r <= cbt_pkg::SEG_PH1;
                            cnt_r <= '0;
                        end
                        else
                            cnt_r <= cnt_r + 1'b1;
                    end
                    cbt_pkg::SEG_PH1:
                    begin
                        if (resync)
                        begin
                            ext_r <= late_ext;
                            synced_r <= 1'b1;
                        end
                        if (ph1_end)
                        begin
                            seg_r <= cbt_pkg::SEG_PH2;
                            cnt_r <= '0;
                            synced_r <= 1'b0;
                        end
                        else
                            cnt_r <= cnt_r + 1'b1;
                    end
                    cbt_pkg::SEG_PH2:
                    begin
                        if (resync && rem <= sjw_tq)
                        begin
                            // error within jump width: edge quantum is the new sync
                            seg_r <= cbt_pkg::SEG_PROP;
                            cnt_r <= '0;
                            ext_r <= '0;
                            shr_r <= '0;
                            synced_r <= 1'b1;
                        end
                        else if (resync)
                        begin
                            shr_r <= sjw_tq;
                            synced_r <= 1'b1;
                            cnt_r <= cnt_r + 1'b1;
                        end
                        else if (ph2_end)
                        begin
                            seg_r <= cbt_pkg::SEG_SYNC;
                            cnt_r <= '0;
                            ext_r <= '0;
                            shr_r <= '0;
                        end
                        else
                            cnt_r <= cnt_r + 1'b1;
                    end
                    default:
                        seg_r <= cbt_pkg::SEG_SYNC;
                endcase
            end
        end
    end
    // ==========================================================
    // sample point
    logic rx_bit_r;
    logic bit_valid_r;
    assign rx_bit = rx_bit_r;
    assign rx_bit_valid = bit_valid_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_bit_r <= 1'b1;
            bit_valid_r <= 1'b0;
        end
        else
        begin
            bit_valid_r <= run && tq_tick && ph1_end && !hard;
            if (run && tq_tick && ph1_end && !hard)
                rx_bit_r <= tsel_r ? maj : bus_lvl;
        end
    end
    // ==========================================================
    // message store and per-word dma hand-off
    logic [WORD_W-1:0] msg_mem [MSG_WORDS];
    logic [PTR_W-1:0] fill_r;
    logic [PTR_W-1:0] ptr_r;
    logic draining_r;
    logic req_r;
    logic ovf_r;
    logic complete;
    logic pop;
    assign complete = msg_wr_en && !draining_r && (fill_r == LAST);
    assign pop = rd_go && (wb_adr_i == cbt_pkg::ADR_RXW) && draining_r;
    assign rx_dma_req = req_r;
    always_ff @(posedge ref_clk)
    begin
        if (msg_wr_en && !draining_r)
            msg_mem[fill_r] <= msg_wr_data;
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fill_r <= '0;
            ptr_r <= '0;
            draining_r <= 1'b0;
            req_r <= 1'b0;
        end
        else
        begin
            req_r <= complete || (pop && ptr_r != LAST);
            if (msg_wr_en && !draining_r)
                fill_r <= complete ? '0 : fill_r + 1'b1;
            if (complete)
            begin
                draining_r <= 1'b1;
                ptr_r <= '0;
            end
            else if (pop)
            begin
                ptr_r <= ptr_r + 1'b1;
                if (ptr_r == LAST)
                    draining_r <= 1'b0;
            end
        end
    end
    // words offered while busy are lost; new event beats a clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ovf_r <= 1'b0;
        else if (msg_wr_en && draining_r)
            ovf_r <= 1'b1;
        else if (wr_go && wb_adr_i == cbt_pkg::ADR_STAT && wb_sel_i[0] && wb_dat_i[cbt_pkg::ST_OVF_BIT])
            ovf_r <= 1'b0;
    end
    // ==========================================================
    // read mux
    always_comb
    begin
        rd_mux = '0;
        case (wb_adr_i)
            cbt_pkg::ADR_CFG_A:
            begin
                rd_mux[cbt_pkg::BRP_LSB +: cbt_pkg::BRP_W] = brp_r;
                rd_mux[cbt_pkg::JW_LSB +: cbt_pkg::JW_W] = jw_r;
            end
            cbt_pkg::ADR_CFG_B:
            begin
                rd_mux[cbt_pkg::PROP_LSB +: cbt_pkg::SEG_W] = prop_r;
                rd_mux[cbt_pkg::PH1_LSB +: cbt_pkg::SEG_W] = ph1_r;
                rd_mux[cbt_pkg::TSEL_BIT] = tsel_r;
                rd_mux[cbt_pkg::P2SRC_BIT] = p2src_r;
                rd_mux[cbt_pkg::PH2_LSB +: cbt_pkg::SEG_W] = ph2_r;
            end
            cbt_pkg::ADR_CTRL:
            begin
                rd_mux[cbt_pkg::REQ_LSB +: cbt_pkg::MODE_W] = req_mode_r;
                rd_mux[cbt_pkg::CUR_LSB +: cbt_pkg::MODE_W] = cur_mode_r;
            end
            cbt_pkg::ADR_RXW:
                rd_mux[WORD_W-1:0] = draining_r ? msg_mem[ptr_r] : '0;
            cbt_pkg::ADR_STAT:
            begin
                rd_mux[cbt_pkg::ST_BUSY_BIT] = draining_r;
                rd_mux[cbt_pkg::ST_OVF_BIT] = ovf_r;
                rd_mux[cbt_pkg::ST_CFGERR_BIT] = cfg_err;
            end
            default:
                rd_mux = '0;
        endcase
    end
    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_sync_one_tq: assert property ((run && tq_tick && !hard && seg_r == cbt_pkg::SEG_SYNC) |=>
        seg_r == cbt_pkg::SEG_PROP && cnt_r == '0)
        else $error("sync segment not one quantum");
    a_sample_point: assert property (rx_bit_valid |->
        seg_r == cbt_pkg::SEG_PH2 && $past(seg_r) == cbt_pkg::SEG_PH1)
        else $error("sample not at phase1 end");
    a_triple_major: assert property ((rx_bit_valid && $past(tsel_r) && $past(samp_r[1:0]) == 2'b00) |->
        !rx_bit)
        else $error("majority vote wrong");
    a_single_samp: assert property ((rx_bit_valid && !$past(tsel_r)) |-> rx_bit == $past(bus_lvl))
        else $error("single sample wrong");
    a_hard_sync: assert property ((run && hard) |=> seg_r == cbt_pkg::SEG_PROP && synced_r)
        else $error("hard sync missed");
    a_ext_capped: assert property (ext_r <= sjw_tq && shr_r <= sjw_tq)
        else $error("jump exceeds width");
    a_msg_req: assert property (complete |=> rx_dma_req && ptr_r == '0 && draining_r)
        else $error("no request on message");
    a_req_per_word: assert property ((pop && ptr_r != LAST) |=> rx_dma_req ##1 !rx_dma_req)
        else $error("word request missing");
    a_req_busy: assert property (rx_dma_req |-> draining_r)
        else $error("request without word");
    a_cfg_locked: assert property ((!$past(cfg_mode) && !$past(rst)) |->
        $stable(brp_r) && $stable(jw_r) && $stable(ph1_r) && $stable(ph2_r) && $stable(prop_r))
        else $error("timing changed outside config");
    a_mode_follow: assert property ($changed(cur_mode_r) |-> cur_mode_r == $past(req_mode_r))
        else $error("mode not requested one");
    c_triple: cover property (rx_bit_valid && $past(tsel_r));
    c_late: cover property (resync && seg_r == cbt_pkg::SEG_PH1);
    c_early: cover property (resync && seg_r == cbt_pkg::SEG_PH2);
    c_drained: cover property (pop && ptr_r == LAST);
endmodule : cbt_core

// file: common/cbt_pkg.sv
// shared constants and types of the can bit timing block
package cbt_pkg;
    // ==========================================================
    // bus and register map
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam logic [7:0] ADR_CFG_A = 8'h00;
    localparam logic [7:0] ADR_CFG_B = 8'h04;
    localparam logic [7:0] ADR_CTRL = 8'h08;
    localparam logic [7:0] ADR_RXW = 8'h0c;
    localparam logic [7:0] ADR_STAT = 8'h10;
    // ==========================================================
    // field layout
    localparam int BRP_W = 6;
    localparam int BRP_LSB = 0;
    localparam int JW_W = 2;
    localparam int JW_LSB = 6;
    localparam int SEG_W = 3;
    localparam int PROP_LSB = 0;
    localparam int PH1_LSB = 3;
    localparam int TSEL_BIT = 6;
    localparam int P2SRC_BIT = 7;
    localparam int PH2_LSB = 8;
    localparam int MODE_W = 3;
    localparam int REQ_LSB = 0;
    localparam int CUR_LSB = 5;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_OVF_BIT = 1;
    localparam int ST_CFGERR_BIT = 2;
    // ==========================================================
    // reset values and encodings
    localparam logic [7:0] CFG_A_RST = 8'h00;
    localparam logic [10:0] CFG_B_RST = 11'h390;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CFG = 3'h4;
    localparam logic [3:0] LEN_OFS = 4'h1;
    localparam logic [4:0] TQ_MIN = 5'h08;
    localparam logic [4:0] TQ_MAX = 5'h19;
    // ==========================================================
    // message port and bit segment type
    localparam int MSG_WORDS = 8;
    localparam int WORD_W = 16;
    typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cbt_seg_t;
endpackage : cbt_pkg

// file: design/cbt_tq_gen.sv
// time quantum enable generator
`timescale 1ns/1ps
module cbt_tq_gen #(
    parameter int BRP_W = cbt_pkg::BRP_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [BRP_W-1:0] quantum_prescaler,
    output logic tq_tick
);
    // ==========================================================
    // divider: period is 2*(prescaler+1) clocks
    logic [BRP_W:0] div_r;
    logic [BRP_W:0] term;
    assign term = {quantum_prescaler, 1'b1};
    assign tq_tick = en && (div_r == term);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            div_r <= '0;
        else if (!en || tq_tick)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end
    // ==========================================================
    // checks
    logic [BRP_W+1:0] gap_r;
    logic seen_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end
        else
        begin
            gap_r <= (tq_tick || !en) ? (BRP_W+2)'(1) : gap_r + 1'b1;
            seen_r <= en && (seen_r || tq_tick);
        end
    end
    a_tq_period: assert property (@(posedge ref_clk) disable iff (rst)
        (tq_tick && seen_r && $stable(quantum_prescaler)) |-> gap_r == {1'b0, term} + 1'b1)
        else $error("quantum period wrong");
    a_tq_min_two: assert property (@(posedge ref_clk) disable iff (rst)
        tq_tick |=> !tq_tick)
        else $error("quantum shorter than two clocks");
endmodule : cbt_tq_gen

// file: design/cbt_pin_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module cbt_pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    // ==========================================================
    // level only moves when stages two and three agree
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    assign level = level_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level_r <= 1'b1;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level_r <= s3_r;
        end
    end
endmodule : cbt_pin_sync

// file: verification/cbt_far_end.sv
// bus transceiver model driving the receive pin
`timescale 1ns/1ps
module cbt_far_end (
    input wire logic ref_clk,
    output logic can_rx_pin
);
    // ==========================================================
    // bit source
    initial can_rx_pin = 1'b1;
    // per is the bit length in ref_clk cycles
    task automatic send(input logic [10:0] p, input int per);
        for (int i = 10; i >= 0; i--)
        begin
            @(posedge ref_clk);
            can_rx_pin <= p[i];
            repeat (per - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        can_rx_pin <= 1'b1;
    endtask : send
endmodule : cbt_far_end

// file: verification/test_cbt_core.sv
// self-checking bench of the bit timing core
`timescale 1ns/1ps
module test_cbt_core;
    // ==========================================================
    // stimulus and checks
    logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, frame_idle = 1, msg_wr_en = 0;
    logic [3:0] sel = 0;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, rd, wb_dat_o;
    logic [15:0] msg_wr_data = 0;
    logic [15:0] w[8];
    logic wb_ack_o, rx_bit, rx_bit_valid, rx_dma_req, can_rx_pin;
    logic [31:0] exq[$];
    logic bq[$];
    logic [31:0] ca[4] = '{32'hc0, 32'hc0, 32'hc0, 32'hc1};
    logic [31:0] cb[4] = '{32'h5bc, 32'h5fc, 32'h5fc, 32'h03c};
    int per[4] = '{40, 42, 38, 88};
    int failures = 0, compares = 0, n;
    cbt_core u_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .can_rx_pin(can_rx_pin), .frame_idle(frame_idle), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
        .msg_wr_en(msg_wr_en), .msg_wr_data(msg_wr_data), .rx_dma_req(rx_dma_req));
    cbt_far_end u_far (.ref_clk(ref_clk), .can_rx_pin(can_rx_pin));
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // for reads d is the expected word
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic chk);
        @(posedge ref_clk);
        cyc <= 1;
        stb <= 1;
        we <= wr;
        adr <= a;
        dat <= d;
        sel <= 4'h3;
        if (chk)
            exq.push_back(d);
        // no local limit: only the watchdog ends a stuck access
        do
            @(posedge ref_clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 0;
        stb <= 0;
    endtask : wb
    task automatic set_mode(input logic [2:0] m);
        int k = 0;
        wb(1, cbt_pkg::ADR_CTRL, {29'h0, m}, 0);
        do
        begin
            wb(0, cbt_pkg::ADR_CTRL, 0, 0);
            k++;
        end
        while (rd[7:5] !== m && k < 20);
        check(rd, {24'h0, m, 2'b0, m});
    endtask : set_mode
    // bit pairs keep a falling edge at least every four bits
    task automatic frame(input int pr);
        logic [10:0] p;
        logic [3:0] r;
        r = 4'($urandom);
        p = {1'b0, r[3], ~r[3], r[2], ~r[2], r[1], ~r[1], r[0], ~r[0], 2'b11};
        for (int i = 10; i >= 0; i--)
            bq.push_back(p[i]);
        fork
            u_far.send(p, pr);
            begin
                repeat (10) @(posedge ref_clk);
                frame_idle <= 0;
            end
        join
        // a fast sender lets the last sample fall after the pin is released
        while (bq.size() != 0)
            @(posedge ref_clk);
        frame_idle <= 1;
    endtask : frame
    always @(posedge ref_clk)
    begin
        if (wb_ack_o === 1'b1 && !we && exq.size() > 0)
            check(wb_dat_o, exq.pop_front());
        if (rx_bit_valid === 1'b1 && !frame_idle)
            check({31'h0, rx_bit}, bq.size() ? {31'h0, bq.pop_front()} : 32'hx);
    end
    initial
    begin
        #300us;
        failures++;
        conclude();
    end
    initial
    begin
        void'($urandom(67));
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        wb(0, cbt_pkg::ADR_CFG_A, 32'h0, 1);
        wb(0, cbt_pkg::ADR_CFG_B, 32'h390, 1);
        wb(0, cbt_pkg::ADR_CTRL, 32'h84, 1);
        wb(0, 8'h14, 0, 1);
        foreach (ca[i])
        begin
            set_mode(cbt_pkg::MODE_CFG);
            wb(1, cbt_pkg::ADR_CFG_A, ca[i], 0);
            wb(1, cbt_pkg::ADR_CFG_B, cb[i], 0);
            wb(0, cbt_pkg::ADR_CFG_A, ca[i], 1);
            wb(0, cbt_pkg::ADR_CFG_B, cb[i], 1);
            set_mode(cbt_pkg::MODE_NORMAL);
            frame(per[i]);
        end
        check(32'(bq.size()), 0);
        wb(1, cbt_pkg::ADR_CFG_A, 32'h3f, 0);
        wb(0, cbt_pkg::ADR_CFG_A, 32'hc1, 1);
        // ninth word arrives while busy: dropped, overflow set
        for (int i = 0; i < 9; i++)
        begin
            @(posedge ref_clk);
            if (i < 8)
                w[i] = 16'($urandom);
            msg_wr_en <= 1;
            msg_wr_data <= (i < 8) ? w[i % 8] : ~w[0];
        end
        @(posedge ref_clk);
        msg_wr_en <= 0;
        // eight reads per message, dma count eight
        for (int i = 0; i < 8; i++)
        begin
            n = 0;
            while (rx_dma_req !== 1'b1 && n < 20)
            begin
                @(posedge ref_clk);
                n++;
            end
            check({31'h0, rx_dma_req}, 32'h1);
            wb(0, cbt_pkg::ADR_RXW, {16'h0, w[i]}, 1);
        end
        wb(0, cbt_pkg::ADR_RXW, 0, 1);
        wb(0, cbt_pkg::ADR_STAT, 32'h2, 1);
        wb(1, cbt_pkg::ADR_STAT, 32'h2, 0);
        wb(0, cbt_pkg::ADR_STAT, 32'h0, 1);
        set_mode(cbt_pkg::MODE_CFG);
        wb(1, cbt_pkg::ADR_CFG_B, 32'h80, 0);
        wb(0, cbt_pkg::ADR_STAT, 32'h4, 1);
        conclude();
    end
endmodule : test_cbt_core
